// ==== buck_regulator_config_regs.sv ====
`timescale 1ns/10ps
// What this block does
// - location 0x00 holds on-time, reserved, current limit, enable delay, enable source and enable bits.
// - on-time code 00 to 11 selects low, medium, high or very high switching frequency.
// - the current-limit bit selects 3.5A when clear and 5A when set.
// - enable source 0 takes on/off from the register enable bit, 1 takes it from the enable pin.
// - output control bit 6 selects pulse skipping when 0 and forced PWM when 1.
// - the overtemperature policy bit latches off at once when 0 and after four events when 1.
// - output control bit 4 discharges the output while powered down when set.
// - location 0x02 holds the output level code passed to the regulation core.
// - location 0x03 reports warning, enable, boot error, soft-start, retry, overheat, latched and power good.
// - a read-then-clear flag returns its value on a read and is cleared by that read.
// - reserved and unimplemented bits read as zero whatever is written.
// - output control bits 3-0 give slew time per volt, 0000 being 200 and larger codes longer.
// - only the low six command bits select the register.
// - reads of unmapped locations return zero and writes there change nothing.
module buck_regulator_config_regs
  import buck_cfg_pkg::*;
#(
  parameter int unsigned delay0_cycles = delay0_cyc,
  parameter int unsigned delay1_cycles = delay1_cyc,
  parameter int unsigned delay2_cycles = delay2_cyc,
  parameter int unsigned delay3_cycles = delay3_cyc,
  parameter logic [1:0]  factory_on_time = dflt_on_time,
  parameter logic        factory_peak_current_limit_select = dflt_peak_current_limit_select,
  parameter logic [7:0]  factory_output_ctl = dflt_output_ctl,
  parameter logic [7:0]  factory_level = dflt_level
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // register access from the serial slave engine
  input  wire logic [7:0]       command_byte,
  input  wire logic             write_strobe,
  input  wire logic [7:0]       write_data,
  input  wire logic             read_strobe,
  output logic      [7:0]       read_data,
  // enable pin, asynchronous
  input  wire logic             enable_pin,
  // regulation core
  input  wire core_conditions_t conditions,
  output core_settings_t        settings,
  output logic                  latched_off
);

  logic [7:0]  control_a;
  logic [7:0]  output_ctl;
  logic [7:0]  output_level;
  logic        pin_meta;
  logic        pin_sync;
  logic [18:0] delay_count;
  logic        converter_on;

  function automatic logic [18:0] delay_target(input logic [1:0] sel);
    case (sel)
      2'b00:   delay_target = delay0_cycles[18:0];
      2'b01:   delay_target = delay1_cycles[18:0];
      2'b10:   delay_target = delay2_cycles[18:0];
      default: delay_target = delay3_cycles[18:0];
    endcase
  endfunction

  // address decode
  wire [5:0] reg_addr = command_byte[addr_bits-1:0];
  wire       sel_a = (reg_addr == addr_control_a);
  wire       sel_ctl = (reg_addr == addr_output_ctl);
  wire       sel_level = (reg_addr == addr_level);
  wire       sel_flags = (reg_addr == addr_flags);
  wire       wr_a = write_strobe & sel_a;
  wire       wr_ctl = write_strobe & sel_ctl;
  wire       wr_level = write_strobe & sel_level;
  wire       flags_read = read_strobe & sel_flags;

  // control fields
  wire [1:0] on_time_select = control_a[pos_on_time +: 2];
  wire       peak_current_limit_select = control_a[pos_peak_current_limit_select];
  wire [1:0] enable_delay_select = control_a[pos_en_delay +: 2];
  wire       enable_from_pin = control_a[pos_en_source];
  wire       register_run_bit = control_a[pos_run];
  wire       full_duty_inhibit = output_ctl[pos_full_duty_inhibit];
  wire       forced_pwm = output_ctl[pos_forced_pwm];
  wire       overheat_latch_policy = output_ctl[pos_overheat_policy];
  wire       output_discharge_enable = output_ctl[pos_discharge];
  wire [3:0] slew_code = output_ctl[pos_slew +: 4];

  // source of converter on/off
  wire run_request = enable_from_pin ? pin_sync : register_run_bit;
  wire delay_done = (delay_count >= delay_target(enable_delay_select));

  // status byte assembly
  wire [7:0] live_flags;
  wire [7:0] flag_value;
  assign live_flags[pos_overheat_warning_flag] = conditions.overheat_warning;
  assign live_flags[pos_en_state] = converter_on;
  assign live_flags[pos_boot_err] = conditions.boot_error;
  assign live_flags[pos_ss_done] = conditions.soft_start_done;
  assign live_flags[pos_retry] = conditions.retry_cycle;
  assign live_flags[pos_overheat] = conditions.overheat;
  assign live_flags[pos_latched] = latched_off;
  assign live_flags[pos_pgood] = conditions.power_good;

  // read multiplexer, unmapped locations give zero
  wire [7:0] read_mux = sel_a     ? (control_a & control_a_used_mask) :
                        sel_ctl   ? output_ctl :
                        sel_level ? output_level :
                        sel_flags ? flag_value :
                                    8'h00;

  always_ff @(posedge mclk) begin
    if (reset) begin
      control_a <= {factory_on_time, 1'b0, factory_peak_current_limit_select, 4'h0};
      output_ctl <= factory_output_ctl;
      output_level <= factory_level;
    end else begin
      // reserved bit never stored, so it cannot read back
      if (wr_a)
        control_a <= write_data & control_a_used_mask;
      if (wr_ctl)
        output_ctl <= write_data;
      if (wr_level)
        output_level <= write_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset)
      read_data <= 8'h00;
    else if (read_strobe)
      read_data <= read_mux;
  end

  // enable pin is asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= enable_pin;
      pin_sync <= pin_meta;
    end
  end

  // enable delay; dropping the request restarts the wait
  always_ff @(posedge mclk) begin
    if (reset) begin
      delay_count <= 19'h0;
      converter_on <= 1'b0;
    end else if (!run_request || latched_off) begin
      delay_count <= 19'h0;
      converter_on <= 1'b0;
    end else if (delay_done) begin
      converter_on <= 1'b1;
    end else begin
      delay_count <= delay_count + 19'h1;
    end
  end

  condition_flags_reg #(
    .rc_mask    (flags_rc_mask)
  ) u_flags (
    .mclk       (mclk),
    .reset      (reset),
    .live       (live_flags),
    .read_clear (flags_read),
    .flags      (flag_value)
  );

  // latch released only by taking the run request away
  overheat_latch u_latch (
    .mclk                  (mclk),
    .reset                 (reset),
    .overheat_latch_policy (overheat_latch_policy),
    .release_latch         (~run_request),
    .overheat              (conditions.overheat),
    .latched_off           (latched_off)
  );

  // settings to the regulation core
  always_comb begin
    settings.on_time_select = switch_freq_t'(on_time_select);
    settings.peak_current_limit_select = peak_current_limit_select;
    settings.peak_current_ma = peak_current_limit_select ?
                               peak_current_limit_select_high_ma : peak_current_limit_select_low_ma;
    settings.full_duty_allowed = ~full_duty_inhibit;
    settings.forced_continuous_switching = forced_pwm;
    settings.light_load_pulse_skip = ~forced_pwm;
    settings.output_discharge_on = output_discharge_enable &
                                   ~converter_on;
    settings.slew_us_per_volt = slew_base_us +
                                slew_step_us * {12'h000, slew_code};
    settings.output_level_code = output_level;
    settings.converter_on = converter_on;
  end

endmodule

// ==== buck_cfg_pkg.sv ====
package buck_cfg_pkg;

  // register locations, low six command bits
  localparam logic [5:0] addr_control_a = 6'h00;
  localparam logic [5:0] addr_output_ctl = 6'h01;
  localparam logic [5:0] addr_level = 6'h02;
  localparam logic [5:0] addr_flags = 6'h03;
  localparam int unsigned addr_bits = 6;

  // converter_control_a fields
  localparam int unsigned pos_on_time = 6;
  localparam int unsigned pos_peak_current_limit_select = 4;
  localparam int unsigned pos_en_delay = 2;
  localparam int unsigned pos_en_source = 1;
  localparam int unsigned pos_run = 0;
  localparam logic [7:0] control_a_used_mask = 8'hdf;

  // output_behaviour_control fields
  localparam int unsigned pos_full_duty_inhibit = 7;
  localparam int unsigned pos_forced_pwm = 6;
  localparam int unsigned pos_overheat_policy = 5;
  localparam int unsigned pos_discharge = 4;
  localparam int unsigned pos_slew = 0;

  // condition_flags bit positions
  localparam int unsigned pos_overheat_warning_flag = 7;
  localparam int unsigned pos_en_state = 6;
  localparam int unsigned pos_boot_err = 5;
  localparam int unsigned pos_ss_done = 4;
  localparam int unsigned pos_retry = 3;
  localparam int unsigned pos_overheat = 2;
  localparam int unsigned pos_latched = 1;
  localparam int unsigned pos_pgood = 0;
  // flags that hold until read (read-then-clear)
  localparam logic [7:0] flags_rc_mask = 8'h2e;

  // stored factory defaults
  localparam logic [1:0] dflt_on_time = 2'h1;
  localparam logic       dflt_peak_current_limit_select = 1'b0;
  localparam logic [7:0] dflt_output_ctl = 8'h10;
  localparam logic [7:0] dflt_level = 8'h3c;

  // overtemperature events before latch-off in the tolerant policy
  localparam logic [2:0] overheat_tolerant_count = 3'h4;

  // enable delay choices
  localparam int unsigned mclk_mhz = 125;
  localparam int unsigned delay0_us = 250;
  localparam int unsigned delay1_us = 1000;
  localparam int unsigned delay2_us = 2000;
  localparam int unsigned delay3_us = 3000;
  localparam int unsigned delay0_cyc = delay0_us * mclk_mhz;
  localparam int unsigned delay1_cyc = delay1_us * mclk_mhz;
  localparam int unsigned delay2_cyc = delay2_us * mclk_mhz;
  localparam int unsigned delay3_cyc = delay3_us * mclk_mhz;

  // current limit and slew figures
  localparam logic [15:0] peak_current_limit_select_low_ma = 16'h0dac;
  localparam logic [15:0] peak_current_limit_select_high_ma = 16'h1388;
  localparam logic [15:0] slew_base_us = 16'h00c8;
  localparam logic [15:0] slew_step_us = 16'h00c8;

  typedef enum logic [1:0] {
    freq_low       = 2'b00,
    freq_medium    = 2'b01,
    freq_high      = 2'b10,
    freq_very_high = 2'b11
  } switch_freq_t;

  typedef struct packed {
    switch_freq_t on_time_select;
    logic         peak_current_limit_select;
    logic [15:0]  peak_current_ma;
    logic         full_duty_allowed;
    logic         forced_continuous_switching;
    logic         light_load_pulse_skip;
    logic         output_discharge_on;
    logic [15:0]  slew_us_per_volt;
    logic [7:0]   output_level_code;
    logic         converter_on;
  } core_settings_t;

  typedef struct packed {
    logic overheat_warning;
    logic boot_error;
    logic soft_start_done;
    logic retry_cycle;
    logic overheat;
    logic power_good;
  } core_conditions_t;

endpackage

// ==== overheat_latch.sv ====
`timescale 1ns/10ps
module overheat_latch
  import buck_cfg_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // controls
  input  wire logic overheat_latch_policy,
  input  wire logic release_latch,
  input  wire logic overheat,
  // result
  output logic      latched_off
);

  logic       overheat_d;
  logic [2:0] event_count;
  logic       overheat_rise;
  logic [2:0] next_count;
  logic       trip;

  assign overheat_rise = overheat & ~overheat_d;
  assign next_count = event_count + 3'h1;
  // policy 0 trips on the first event, 1 on the fourth
  assign trip = overheat_rise &
                (~overheat_latch_policy ||
                 next_count >= overheat_tolerant_count);

  always_ff @(posedge mclk) begin
    if (reset) begin
      overheat_d  <= 1'b0;
      event_count <= 3'h0;
      latched_off <= 1'b0;
    end else begin
      overheat_d <= overheat;
      if (release_latch) begin
        event_count <= 3'h0;
        latched_off <= 1'b0;
      end else begin
        if (overheat_rise && !latched_off)
          event_count <= next_count;
        if (trip)
          latched_off <= 1'b1;
      end
    end
  end

endmodule

// ==== condition_flags_reg.sv ====
`timescale 1ns/10ps
module condition_flags_reg
  import buck_cfg_pkg::*;
#(
  parameter logic [7:0] rc_mask = flags_rc_mask
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // live conditions and read strobe
  input  wire logic [7:0] live,
  input  wire logic       read_clear,
  // visible flag value
  output logic      [7:0] flags
);

  logic [7:0] sticky;
  logic [7:0] next_sticky;

  // a fresh event in the clearing cycle survives: set beats clear
  assign next_sticky = (live & rc_mask) |
                       (read_clear ? 8'h00 : sticky);
  assign flags = (live & ~rc_mask) | sticky;

  always_ff @(posedge mclk) begin
    if (reset)
      sticky <= 8'h00;
    else
      sticky <= next_sticky;
  end

endmodule

// ==== host_model.sv ====
`timescale 1ns/10ps
module host_model (
  // clock
  input  wire logic       mclk,
  // register port
  output logic      [7:0] command_byte,
  output logic            write_strobe,
  output logic      [7:0] write_data,
  output logic            read_strobe,
  input  wire logic [7:0] read_data
);
  initial begin
    command_byte = 8'h00;
    write_strobe = 1'b0;
    write_data = 8'h00;
    read_strobe = 1'b0;
  end
  // data is scrambled after use so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    command_byte = a;
    write_data = d;
    write_strobe = 1'b1;
    @(posedge mclk);
    #1;
    write_strobe = 1'b0;
    write_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    command_byte = a;
    read_strobe = 1'b1;
    @(posedge mclk);
    #1;
    read_strobe = 1'b0;
    d = read_data;
  endtask
endmodule

// ==== buck_cfg_properties.sv ====
`timescale 1ns/10ps
module buck_cfg_properties
  import buck_cfg_pkg::*;
(
  // clock and reset
  input wire logic           mclk,
  input wire logic           reset,
  // register port
  input wire logic [7:0]     command_byte,
  input wire logic           write_strobe,
  input wire logic [7:0]     write_data,
  input wire logic           read_strobe,
  input wire logic [7:0]     read_data,
  // core side
  input wire core_settings_t settings,
  input wire logic           latched_off
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire [5:0] adr = command_byte[5:0];
  rst_clear_a: assert property ($fell(reset) |-> read_data == 8'h00
    && !latched_off) else $error("reset state wrong");
  unmapped_zero_a: assert property (read_strobe && adr > 6'h03
    |=> read_data == 8'h00) else $error("unmapped read not zero");
  reserved_zero_a: assert property (read_strobe && adr == 6'h00
    |=> !read_data[5]) else $error("reserved bit set");
  level_read_a: assert property (read_strobe && adr == 6'h02
    |=> read_data == $past(settings.output_level_code))
    else $error("level read wrong");
  level_write_a: assert property (write_strobe && adr == 6'h02
    |=> settings.output_level_code == $past(write_data))
    else $error("level write lost");
  peak_current_limit_select_value_a: assert property (settings.peak_current_ma ==
    (settings.peak_current_limit_select ? 16'h1388 : 16'h0dac))
    else $error("current limit wrong");
  skip_mode_a: assert property (settings.light_load_pulse_skip
    != settings.forced_continuous_switching) else $error("mode clash");
  discharge_off_a: assert property (settings.output_discharge_on
    |-> !settings.converter_on) else $error("discharge while on");
  latch_stop_a: assert property ($rose(latched_off)
    |-> ##2 !settings.converter_on) else $error("runs while latched");
endmodule
bind buck_regulator_config_regs buck_cfg_properties i_buck_cfg_properties (
  .mclk(mclk), .reset(reset), .command_byte(command_byte),
  .write_strobe(write_strobe), .write_data(write_data),
  .read_strobe(read_strobe), .read_data(read_data),
  .settings(settings), .latched_off(latched_off));

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import buck_cfg_pkg::*;
  logic             mclk;
  logic             reset;
  logic [7:0]       command_byte;
  logic             write_strobe;
  logic [7:0]       write_data;
  logic             read_strobe;
  logic [7:0]       read_data;
  logic             enable_pin;
  core_conditions_t conditions;
  core_settings_t   settings;
  logic             latched_off;
  int               errors;
  int               compares;
  // short delay counts keep the run brief
  buck_regulator_config_regs #(.delay0_cycles(10), .delay1_cycles(20),
    .delay2_cycles(30), .delay3_cycles(40)) i_buck_regulator_config_regs (
    .mclk(mclk), .reset(reset), .command_byte(command_byte),
    .write_strobe(write_strobe), .write_data(write_data),
    .read_strobe(read_strobe), .read_data(read_data),
    .enable_pin(enable_pin), .conditions(conditions),
    .settings(settings), .latched_off(latched_off));
  host_model i_host_model (.mclk(mclk), .command_byte(command_byte),
    .write_strobe(write_strobe), .write_data(write_data),
    .read_strobe(read_strobe), .read_data(read_data));
  task automatic check(input string w, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a, e);
    logic [7:0] d;
    i_host_model.rd(a, d);
    check(w, d, e);
  endtask
  task automatic wait_on(output int n);
    n = 0;
    while (settings.converter_on !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic pulse();
    @(posedge mclk);
    #1;
    conditions.overheat = 1'b1;
    @(posedge mclk);
    #1;
    conditions.overheat = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    rd_chk("ctl_a", 8'h00, 8'h40);
    rd_chk("out_ctl", 8'h01, 8'h10);
    rd_chk("level", 8'h02, 8'h3c);
    rd_chk("flags", 8'h03, 8'h00);
  endtask
  task automatic t_access();
    i_host_model.wr(8'h00, 8'hff);
    rd_chk("ctl_a", 8'h00, 8'hdf);
    i_host_model.wr(8'hc2, 8'ha5);
    rd_chk("level", 8'h02, 8'ha5);
    check("core_lvl", settings.output_level_code, 8'ha5);
    i_host_model.wr(8'h3f, 8'h00);
    i_host_model.wr(8'h03, 8'hff);
    rd_chk("unmapped", 8'h3f, 8'h00);
    rd_chk("level2", 8'h02, 8'ha5);
    rd_chk("flags_w", 8'h03, 8'h00);
    conditions = 6'b111101;
    rd_chk("flags_live", 8'h03, 8'hb9);
    conditions = 6'b000000;
    rd_chk("flags_rc", 8'h03, 8'h28);
    rd_chk("flags_clr", 8'h03, 8'h00);
  endtask
  task automatic t_decode();
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = 3'(k);
      i_host_model.wr(8'h00, {i[2:1], 1'b0, i[0], 4'h0});
      check("freq", settings.on_time_select, i[2:1]);
      check("peak_current_limit_select", settings.peak_current_ma,
        i[0] ? 16'h1388 : 16'h0dac);
    end
    for (int k = 0; k < 4; k++) begin
      i = 3'(k);
      i_host_model.wr(8'h01, {i[1], i[0], 2'b01, 2'b00, i[1:0]});
      check("full", settings.full_duty_allowed, !i[1]);
      check("forced_continuous_switching", settings.forced_continuous_switching, i[0]);
      check("skip", settings.light_load_pulse_skip, !i[0]);
      check("dis", settings.output_discharge_on, 1'b1);
      check("slew", settings.slew_us_per_volt, 16'(200 * (k + 1)));
    end
  endtask
  task automatic t_enable();
    int n;
    i_host_model.wr(8'h01, 8'h10);
    i_host_model.wr(8'h00, 8'h01);
    wait_on(n);
    check("delay", n >= 9 && n <= 13, 1'b1);
    check("dis_on", settings.output_discharge_on, 1'b0);
    rd_chk("en_stat", 8'h03, 8'h40);
    i_host_model.wr(8'h00, 8'h02);
    repeat (3) @(posedge mclk);
    #1;
    check("pin_off", settings.converter_on, 1'b0);
    enable_pin = 1'b1;
    wait_on(n);
    check("pin_on", settings.converter_on, 1'b1);
    #1;
    enable_pin = 1'b0;
  endtask
  task automatic t_overheat();
    int n;
    i_host_model.wr(8'h01, 8'h20);
    i_host_model.wr(8'h00, 8'h01);
    wait_on(n);
    repeat (3) pulse();
    check("lat3", latched_off, 1'b0);
    pulse();
    check("lat4", latched_off, 1'b1);
    rd_chk("ot_rc", 8'h03, 8'h06);
    rd_chk("ot_rc2", 8'h03, 8'h02);
    i_host_model.wr(8'h00, 8'h00);
    repeat (3) @(posedge mclk);
    #1;
    check("release", latched_off, 1'b0);
    i_host_model.wr(8'h01, 8'h00);
    i_host_model.wr(8'h00, 8'h01);
    wait_on(n);
    pulse();
    check("lat1", latched_off, 1'b1);
  endtask
  task automatic give_verdict();
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    reset = 1'b1;
    enable_pin = 1'b0;
    conditions = '0;
    errors = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_reset();
    t_access();
    t_decode();
    t_enable();
    t_overheat();
    give_verdict();
  end
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
endmodule
